//--- logic/tpg_consts.svh
// Purpose: Constants for the two-port general purpose I/O block
// Assumes: Register indices are data-memory locations chosen for this block
// Notes: Definitions only
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH
`define TPG_ADDR_PA_DATA 3'h0
`define TPG_ADDR_PA_DIR 3'h1
`define TPG_ADDR_PA_PU 3'h2
`define TPG_ADDR_PA_WAKE 3'h3
`define TPG_ADDR_PB_DATA 3'h4
`define TPG_ADDR_PB_DIR 3'h5
`define TPG_ADDR_PB_PU 3'h6
`define TPG_PA_W 8
`define TPG_PB_W 6
`define TPG_RST_PA_DATA 8'hFF
`define TPG_RST_PA_DIR 8'hFF
`define TPG_RST_PA_PU 8'h00
`define TPG_RST_PA_WAKE 8'h00
`define TPG_RST_PB_DATA 6'h3F
`define TPG_RST_PB_DIR 6'h3F
`define TPG_RST_PB_PU 6'h00
`define TPG_FUNC_GPIO 2'h0
`define TPG_FUNC_NMOS 2'h1
`define TPG_FUNC_OTHER 2'h2
`endif

//--- logic/tpg_pkg.sv
// Purpose: Types for the two-port general purpose I/O block
// Assumes: Constants header supplies widths
// Notes: Holds the register set struct and the reset-kind enum
`include "tpg_consts.svh"
package tpg_pkg;
	typedef enum logic [1:0] {
		TPG_RST_NONE = 2'b00,
		TPG_RST_FULL = 2'b01,
		TPG_RST_KEEP = 2'b10
	} tpg_rst_kind_t;
	typedef struct packed {
		logic [`TPG_PA_W-1:0] pa_data;
		logic [`TPG_PA_W-1:0] pa_dir;
		logic [`TPG_PA_W-1:0] pa_pu;
		logic [`TPG_PA_W-1:0] pa_wake;
		logic [`TPG_PB_W-1:0] pb_data;
		logic [`TPG_PB_W-1:0] pb_dir;
		logic [`TPG_PB_W-1:0] pb_pu;
	} tpg_regs_t;
	typedef struct packed {
		logic [`TPG_PA_W-1:0] s1;
		logic [`TPG_PA_W-1:0] s2;
		logic [`TPG_PA_W-1:0] prev;
	} tpg_sync_t;
endpackage : tpg_pkg

//--- logic/tpg_sync.sv
// Purpose: Two-stage synchroniser and falling-edge detector for port A
// Assumes: Pins are asynchronous to core_clk_i
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"
module tpg_sync (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [`TPG_PA_W-1:0] pin_i,
	output logic [`TPG_PA_W-1:0] level_o,
	output logic [`TPG_PA_W-1:0] fall_o
);
	tpg_pkg::tpg_sync_t st_r;
	tpg_pkg::tpg_sync_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
	end
	// Reset high so a released pin does not look like a falling edge
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_r <= {3{8'hFF}};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign level_o = st_r.s2;
	assign fall_o = st_r.prev & ~st_r.s2;
endmodule : tpg_sync
`default_nettype wire

//--- logic/tpg_pad.sv
// Purpose: Per-pin drive and pull-high control for one port
// Assumes: Function select comes from the pin-sharing logic
// Notes: Pure combinational
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"
module tpg_pad #(
	parameter int W = 8
) (
	input wire logic [W-1:0] dir_i,
	input wire logic [W-1:0] data_i,
	input wire logic [W-1:0] pu_i,
	input wire logic [2*W-1:0] func_i,
	output logic [W-1:0] out_o,
	output logic [W-1:0] oe_o,
	output logic [W-1:0] pu_o
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_pin
			logic gp;
			logic nm;
			assign gp = func_i[2*g+:2] == `TPG_FUNC_GPIO;
			assign nm = func_i[2*g+:2] == `TPG_FUNC_NMOS;
			// Zero selects CMOS output, one selects input
			assign oe_o[g] = gp & ~dir_i[g];
			assign out_o[g] = data_i[g];
			// Pull-high only for digital input or NMOS output
			assign pu_o[g] = pu_i[g] & ((gp & dir_i[g]) | nm);
		end
	endgenerate
endmodule : tpg_pad
`default_nettype wire

//--- logic/tpg_top.sv
// Purpose: Two-port general purpose I/O with port A wake-up
// Assumes: Processor gives one-cycle read/write strobes on a data-memory port
// Notes: Port inputs are synchronised; wake is a registered level
// Functional notes
// - Full resets set all direction and data bits to one
// - Full resets clear pull and wake enables; keep-reset changes nothing
// - Written output value held until that latch is written again
// - Direction bit one means input, zero means CMOS output
// - Reading an output pin returns its latch value, not the pin
// - Each pin has its own pull-high enable bit
// - Pull-high only applies for digital input or NMOS output function
// - Enabled port A pin falling edge wakes device from idle or sleep
// - Wake honoured only for general inputs while in idle or sleep
// - Port A has eight pins, port B six; unused bits read zero
// - Same bit index drives same pin across all registers of a port
// - Bit set and clear read whole register, modify, write back
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"
module tpg_top (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire tpg_pkg::tpg_rst_kind_t rst_kind_i,
	input wire logic [2:0] addr_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] wdata_i,
	input wire logic bit_op_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic bit_val_i,
	input wire logic low_power_i,
	input wire logic [2*`TPG_PA_W-1:0] pa_func_i,
	input wire logic [2*`TPG_PB_W-1:0] pb_func_i,
	input wire logic [`TPG_PA_W-1:0] pa_pin_i,
	input wire logic [`TPG_PB_W-1:0] pb_pin_i,
	output logic [7:0] rdata_o,
	output logic [`TPG_PA_W-1:0] pa_out_o,
	output logic [`TPG_PA_W-1:0] pa_oe_o,
	output logic [`TPG_PA_W-1:0] pa_pu_o,
	output logic [`TPG_PB_W-1:0] pb_out_o,
	output logic [`TPG_PB_W-1:0] pb_oe_o,
	output logic [`TPG_PB_W-1:0] pb_pu_o,
	output logic wake_o
);
	typedef struct packed {
		tpg_pkg::tpg_regs_t regs;
		logic [7:0] rdata;
		logic [`TPG_PA_W-1:0] pa_out;
		logic [`TPG_PA_W-1:0] pa_oe;
		logic [`TPG_PA_W-1:0] pa_pu;
		logic [`TPG_PB_W-1:0] pb_out;
		logic [`TPG_PB_W-1:0] pb_oe;
		logic [`TPG_PB_W-1:0] pb_pu;
		logic [`TPG_PB_W-1:0] pb_s1;
		logic [`TPG_PB_W-1:0] pb_s2;
		logic wake;
	} tpg_state_t;

	tpg_state_t st_r;
	tpg_state_t st_nxt;
	logic [`TPG_PA_W-1:0] pa_lvl;
	logic [`TPG_PA_W-1:0] pa_fall;
	logic [`TPG_PA_W-1:0] pa_out_c;
	logic [`TPG_PA_W-1:0] pa_oe_c;
	logic [`TPG_PA_W-1:0] pa_pu_c;
	logic [`TPG_PB_W-1:0] pb_out_c;
	logic [`TPG_PB_W-1:0] pb_oe_c;
	logic [`TPG_PB_W-1:0] pb_pu_c;
	logic [`TPG_PA_W-1:0] pa_gpin;
	logic [7:0] cur;
	logic [7:0] wval;
	logic [7:0] mask;
	logic sync_rst;

	// Keep-reset comes in sleep; reloading the edge detector then would
	// make a pin that is already low look like a fresh falling edge
	assign sync_rst = sys_rst_i && rst_kind_i != tpg_pkg::TPG_RST_KEEP;

	// Port A pins cross into the clock domain before any use
	tpg_sync u_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sync_rst),
		.pin_i(pa_pin_i),
		.level_o(pa_lvl),
		.fall_o(pa_fall)
	);

	tpg_pad #(.W(`TPG_PA_W)) u_pad_a (
		.dir_i(st_nxt.regs.pa_dir),
		.data_i(st_nxt.regs.pa_data),
		.pu_i(st_nxt.regs.pa_pu),
		.func_i(pa_func_i),
		.out_o(pa_out_c),
		.oe_o(pa_oe_c),
		.pu_o(pa_pu_c)
	);

	tpg_pad #(.W(`TPG_PB_W)) u_pad_b (
		.dir_i(st_nxt.regs.pb_dir),
		.data_i(st_nxt.regs.pb_data),
		.pu_i(st_nxt.regs.pb_pu),
		.func_i(pb_func_i),
		.out_o(pb_out_c),
		.oe_o(pb_oe_c),
		.pu_o(pb_pu_c)
	);

	// Register read view: inputs show the pin, outputs show the latch
	function automatic logic [7:0] view(input logic [2:0] a,
		input tpg_pkg::tpg_regs_t r, input logic [7:0] pa_l,
		input logic [5:0] pb_l);
		logic [7:0] v;
		v = 8'h00;
		if (a == `TPG_ADDR_PA_DATA) begin
			v = (r.pa_dir & pa_l) | (~r.pa_dir & r.pa_data);
		end else if (a == `TPG_ADDR_PA_DIR) begin
			v = r.pa_dir;
		end else if (a == `TPG_ADDR_PA_PU) begin
			v = r.pa_pu;
		end else if (a == `TPG_ADDR_PA_WAKE) begin
			v = r.pa_wake;
		end else if (a == `TPG_ADDR_PB_DATA) begin
			v = {2'h0, (r.pb_dir & pb_l) | (~r.pb_dir & r.pb_data)};
		end else if (a == `TPG_ADDR_PB_DIR) begin
			v = {2'h0, r.pb_dir};
		end else if (a == `TPG_ADDR_PB_PU) begin
			v = {2'h0, r.pb_pu};
		end else begin
			v = 8'h00;
		end
		return v;
	endfunction : view

	// Sampled pin levels stand in for the read point on the pin
	assign cur = view(addr_i, st_r.regs, pa_lvl, st_r.pb_s2);

	genvar g;
	generate
		for (g = 0; g < `TPG_PA_W; g++) begin : g_wk
			assign pa_gpin[g] = st_r.regs.pa_dir[g] &
				(pa_func_i[2*g+:2] == `TPG_FUNC_GPIO);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		mask = 8'h01 << bit_sel_i;
		// Bit operations rebuild the whole byte from the current view
		wval = bit_op_i ? ((cur & ~mask) | (bit_val_i ? mask : 8'h00))
			: wdata_i;
		st_nxt.pb_s1 = pb_pin_i;
		st_nxt.pb_s2 = st_r.pb_s1;
		if (wr_en_i) begin
			if (addr_i == `TPG_ADDR_PA_DATA) begin
				st_nxt.regs.pa_data = wval;
			end else if (addr_i == `TPG_ADDR_PA_DIR) begin
				st_nxt.regs.pa_dir = wval;
			end else if (addr_i == `TPG_ADDR_PA_PU) begin
				st_nxt.regs.pa_pu = wval;
			end else if (addr_i == `TPG_ADDR_PA_WAKE) begin
				st_nxt.regs.pa_wake = wval;
			end else if (addr_i == `TPG_ADDR_PB_DATA) begin
				st_nxt.regs.pb_data = wval[5:0];
			end else if (addr_i == `TPG_ADDR_PB_DIR) begin
				st_nxt.regs.pb_dir = wval[5:0];
			end else if (addr_i == `TPG_ADDR_PB_PU) begin
				st_nxt.regs.pb_pu = wval[5:0];
			end
		end
		st_nxt.rdata = rd_en_i ? cur : st_r.rdata;
		// Wake is a level held until low power is left
		if (!low_power_i) begin
			st_nxt.wake = 1'b0;
		end else if (|(pa_fall & st_r.regs.pa_wake & pa_gpin)) begin
			st_nxt.wake = 1'b1;
		end
		st_nxt.pa_out = pa_out_c;
		st_nxt.pa_oe = pa_oe_c;
		st_nxt.pa_pu = pa_pu_c;
		st_nxt.pb_out = pb_out_c;
		st_nxt.pb_oe = pb_oe_c;
		st_nxt.pb_pu = pb_pu_c;
	end

	// Keep-reset leaves everything, so pins do not glitch on idle time-out
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i && rst_kind_i != tpg_pkg::TPG_RST_KEEP) begin
			st_r <= '0;
			st_r.regs.pa_data <= `TPG_RST_PA_DATA;
			st_r.regs.pa_dir <= `TPG_RST_PA_DIR;
			st_r.regs.pb_data <= `TPG_RST_PB_DATA;
			st_r.regs.pb_dir <= `TPG_RST_PB_DIR;
			st_r.regs.pa_pu <= `TPG_RST_PA_PU;
			st_r.regs.pa_wake <= `TPG_RST_PA_WAKE;
			st_r.regs.pb_pu <= `TPG_RST_PB_PU;
			st_r.pa_out <= `TPG_RST_PA_DATA;
			st_r.pb_out <= `TPG_RST_PB_DATA;
		end else if (!sys_rst_i) begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign pa_out_o = st_r.pa_out;
	assign pa_oe_o = st_r.pa_oe;
	assign pa_pu_o = st_r.pa_pu;
	assign pb_out_o = st_r.pb_out;
	assign pb_oe_o = st_r.pb_oe;
	assign pb_pu_o = st_r.pb_pu;
	assign wake_o = st_r.wake;
endmodule : tpg_top
`default_nettype wire

//--- verification/tpg_sva.sv
// Purpose: Port-level checks for tpg_top
// Assumes: Sync active-high reset, one clock
// Notes: Bound to tpg_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"
module tpg_sva (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire tpg_pkg::tpg_rst_kind_t rst_kind_i,
	input wire logic [2:0] addr_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] wdata_i,
	input wire logic bit_op_i,
	input wire logic low_power_i,
	input wire logic [15:0] pa_func_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] pa_out_o,
	input wire logic [7:0] pa_oe_o,
	input wire logic [7:0] pa_pu_o,
	input wire logic wake_o
);
	logic [7:0] pu_ok;
	logic full_rst;
	logic keep_rst;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pu_ok[i] = ~pa_func_i[2*i+1];
		end
	end
	assign keep_rst = sys_rst_i && rst_kind_i == tpg_pkg::TPG_RST_KEEP;
	assign full_rst = sys_rst_i && !keep_rst;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_full_reset: assert property (disable iff (1'b0)
		full_rst |=> pa_out_o == 8'hFF && pa_oe_o == 8'h00 &&
		pa_pu_o == 8'h00 && !wake_o) else $error("full reset state wrong");
	a_keep_frozen: assert property (disable iff (1'b0)
		keep_rst |=> $stable(pa_out_o) && $stable(pa_pu_o))
		else $error("keep reset changed outputs");
	a_data_write: assert property (
		wr_en_i && !bit_op_i && addr_i == `TPG_ADDR_PA_DATA
		|=> pa_out_o == $past(wdata_i)) else $error("data write lost");
	a_dir_write: assert property (
		wr_en_i && !bit_op_i && addr_i == `TPG_ADDR_PA_DIR &&
		pa_func_i == 16'h0000 |=> pa_oe_o == ~$past(wdata_i))
		else $error("direction not applied");
	a_out_hold: assert property (
		!wr_en_i |=> $stable(pa_out_o)) else $error("latch changed");
	a_pull_gate: assert property (
		(pa_pu_o & ~$past(pu_ok)) == 8'h00) else $error("pull on wrongly");
	a_read_latch: assert property (
		rd_en_i && !wr_en_i && addr_i == `TPG_ADDR_PA_DATA
		|=> ((rdata_o ^ $past(pa_out_o)) & $past(pa_oe_o)) == 8'h00)
		else $error("output bit read not latch");
	a_rsv_zero: assert property (
		rd_en_i && addr_i[2] |=> rdata_o[7:6] == 2'b00)
		else $error("unused bits not zero");
	a_wake_idle: assert property (
		!low_power_i |=> !wake_o) else $error("wake while running");
endmodule : tpg_sva
bind tpg_top tpg_sva u_sva (.core_clk_i, .sys_rst_i, .rst_kind_i, .addr_i,
	.wr_en_i, .rd_en_i, .wdata_i, .bit_op_i, .low_power_i, .pa_func_i,
	.rdata_o, .pa_out_o, .pa_oe_o, .pa_pu_o, .wake_o);
`default_nettype wire

//--- verification/tpg_pins.sv
// Purpose: Switches and wiring outside the two ports
// Assumes: Device drive beats a switch
// Notes: Undriven pins toggle so a floating read never passes by luck
`timescale 1ns/1ps
`default_nettype none
module tpg_pins (
	input wire logic core_clk_i,
	input wire logic [7:0] a_out_i,
	input wire logic [7:0] a_oe_i,
	input wire logic [7:0] a_pu_i,
	input wire logic [5:0] b_out_i,
	input wire logic [5:0] b_oe_i,
	input wire logic [5:0] b_pu_i,
	input wire logic [7:0] sw_en_i,
	input wire logic [7:0] sw_i,
	output logic [7:0] a_pin_o,
	output logic [5:0] b_pin_o
);
	logic [7:0] flt = 8'h55;
	always @(posedge core_clk_i) flt <= ~flt;
	// Switch levels only change between reads, off the sampling edge
	assign a_pin_o = a_oe_i & a_out_i | ~a_oe_i & (sw_en_i & sw_i |
		~sw_en_i & (a_pu_i | flt));
	assign b_pin_o = b_oe_i & b_out_i | ~b_oe_i & (b_pu_i | flt[5:0]);
endmodule : tpg_pins
`default_nettype wire

//--- verification/two_port_gpio_with_wake_tb.sv
// Purpose: Self-checking bench for tpg_top
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Reads of input pins allow for the two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module two_port_gpio_with_wake_tb;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	tpg_pkg::tpg_rst_kind_t rst_kind_i = tpg_pkg::TPG_RST_FULL;
	logic [2:0] addr_i = 3'h0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic bit_op_i = 1'b0;
	logic [2:0] bit_sel_i = 3'h0;
	logic bit_val_i = 1'b0;
	logic low_power_i = 1'b0;
	logic [15:0] pa_func_i = 16'h0000;
	logic [11:0] pb_func_i = 12'h000;
	logic [7:0] sw_en = 8'h00;
	logic [7:0] sw = 8'h00;
	wire [7:0] pa_pin_i, rdata_o, pa_out_o, pa_oe_o, pa_pu_o;
	wire [5:0] pb_pin_i, pb_out_o, pb_oe_o, pb_pu_o;
	wire wake_o;
	int error_cnt = 0;
	int num_checks = 0;
	logic [7:0] v;
	tpg_top u_dut (.core_clk_i, .sys_rst_i, .rst_kind_i, .addr_i, .wr_en_i,
		.rd_en_i, .wdata_i, .bit_op_i, .bit_sel_i, .bit_val_i, .low_power_i,
		.pa_func_i, .pb_func_i, .pa_pin_i, .pb_pin_i, .rdata_o, .pa_out_o,
		.pa_oe_o, .pa_pu_o, .pb_out_o, .pb_oe_o, .pb_pu_o, .wake_o);
	tpg_pins u_pins (.core_clk_i, .a_out_i(pa_out_o), .a_oe_i(pa_oe_o),
		.a_pu_i(pa_pu_o), .b_out_i(pb_out_o), .b_oe_i(pb_oe_o),
		.b_pu_i(pb_pu_o), .sw_en_i(sw_en), .sw_i(sw), .a_pin_o(pa_pin_i),
		.b_pin_o(pb_pin_i));
	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : tick
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		tick(1);
		addr_i = a;
		wdata_i = d;
		wr_en_i = 1'b1;
		tick(1);
		wr_en_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		tick(1);
		addr_i = a;
		rd_en_i = 1'b1;
		tick(1);
		rd_en_i = 1'b0;
		v = rdata_o;
	endtask : rd
	task automatic bitop(input logic [2:0] a, input logic [2:0] s,
		input logic b);
		tick(1);
		addr_i = a;
		bit_sel_i = s;
		bit_val_i = b;
		bit_op_i = 1'b1;
		wr_en_i = 1'b1;
		tick(1);
		wr_en_i = 1'b0;
		bit_op_i = 1'b0;
	endtask : bitop
	task automatic rst(input tpg_pkg::tpg_rst_kind_t k, input int n);
		rst_kind_i = k;
		sys_rst_i = 1'b1;
		tick(n);
		sys_rst_i = 1'b0;
	endtask : rst
	task automatic conclude();
		if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic t_reset();
		logic [7:0] e [8];
		e = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00};
		chk(pa_out_o, 8'hFF);
		chk({2'b00, pb_oe_o}, 8'h00);
		for (int i = 1; i < 8; i++) if (i != 4) begin
			rd(i[2:0]);
			chk(v, e[i]);
		end
	endtask : t_reset
	task automatic t_out();
		wr(3'h1, 8'h00);
		wr(3'h0, 8'hA5);
		chk(pa_oe_o, 8'hFF);
		rd(3'h0);
		chk(v, 8'hA5);
		wr(3'h4, 8'hFF);
		wr(3'h5, 8'h00);
		rd(3'h4);
		chk(v, 8'h3F);
		chk(pa_out_o, 8'hA5);
	endtask : t_out
	task automatic t_portb();
		wr(3'h4, 8'h2A);
		chk({2'b00, pb_out_o}, 8'h2A);
		chk({2'b00, pb_oe_o}, 8'h3F);
		wr(3'h5, 8'hFF);
		wr(3'h6, 8'hFF);
		tick(3);
		rd(3'h4);
		chk(v, 8'h3F);
		pb_func_i = 12'h020;
		tick(2);
		chk({2'b00, pb_pu_o}, 8'h3B);
		pb_func_i = 12'h000;
	endtask : t_portb
	task automatic t_in();
		wr(3'h1, 8'hFF);
		wr(3'h2, 8'hFF);
		sw_en = 8'h0F;
		tick(3);
		rd(3'h0);
		chk(v, 8'hF0);
		pa_func_i = 16'h00E4;
		tick(2);
		chk(pa_pu_o, 8'hF3);
		pa_func_i = 16'h0000;
	endtask : t_in
	task automatic t_bit();
		wr(3'h1, 8'h0F);
		wr(3'h0, 8'h00);
		sw = 8'hFF;
		tick(3);
		bitop(3'h0, 3'h7, 1'b1);
		chk(pa_out_o, 8'h8F);
		bitop(3'h1, 3'h0, 1'b0);
		chk(pa_oe_o, 8'hF1);
	endtask : t_bit
	task automatic t_wake();
		wr(3'h1, 8'hFF);
		wr(3'h3, 8'h01);
		sw_en = 8'h03;
		sw = 8'h03;
		low_power_i = 1'b1;
		tick(4);
		sw = 8'h02;
		tick(6);
		chk({7'h00, wake_o}, 8'h01);
		low_power_i = 1'b0;
		tick(1);
		chk({7'h00, wake_o}, 8'h00);
		low_power_i = 1'b1;
		sw = 8'h00;
		tick(6);
		chk({7'h00, wake_o}, 8'h00);
		wr(3'h3, 8'h02);
		pa_func_i = 16'h0008;
		sw = 8'h02;
		tick(4);
		sw = 8'h00;
		tick(6);
		chk({7'h00, wake_o}, 8'h00);
		pa_func_i = 16'h0000;
		low_power_i = 1'b0;
	endtask : t_wake
	task automatic t_keep();
		wr(3'h2, 8'h5A);
		rst(tpg_pkg::TPG_RST_KEEP, 2);
		rd(3'h2);
		chk(v, 8'h5A);
		rst(tpg_pkg::TPG_RST_FULL, 2);
		rd(3'h2);
		chk(v, 8'h00);
	endtask : t_keep
	initial begin
		tick(16);
		sys_rst_i = 1'b0;
		t_reset();
		t_out();
		t_portb();
		t_in();
		t_bit();
		t_wake();
		t_keep();
		conclude();
	end
	initial begin
		#50000;
		error_cnt++;
		conclude();
	end
endmodule : two_port_gpio_with_wake_tb
`default_nettype wire
